//--- core/cbtd_top.sv
`timescale 1ns/1ps
module cbtd_top #(
   parameter int WAKE_FILTER_CYCLES = 16
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Host register access
   input  wire logic                   cfg_mode,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   output logic [7:0]                  reg_rdata_q,
   // Bus pins
   input  wire logic                   can_rx,
   output logic                        can_tx_q,
   // Frame engine
   input  wire cbtd_pkg::cbtd_field_t  field,
   input  wire logic                   transmitting,
   input  wire logic                   tx_bit,
   input  wire logic                   crc_bit_en,
   // Results
   output logic                        sample_q,
   output logic                        rx_bit_q,
   output logic [cbtd_pkg::CRC_W-1:0]  crc_seq_q,
   output cbtd_pkg::cbtd_err_t         err_q,
   output logic                        error_frame_q,
   output logic                        repeat_req_q,
   output logic                        wake_q
);

   // Filter counter is 16 bits, so the span must fit in it; refused at elaboration
   if (WAKE_FILTER_CYCLES < 1 || WAKE_FILTER_CYCLES > 65535) begin : g_wake_range
      $error("WAKE_FILTER_CYCLES out of range");
   end

   logic [7:0]                prescaler_jump_config_q;
   logic [7:0]                segment_sampling_config_q;
   logic [7:0]                phase2_wakeup_config_q;
   cbtd_pkg::cbtd_timing_t    tcfg;
   logic                      rx_sync;
   logic                      sample_s;
   logic                      bit_val;
   logic                      crc_region;
   logic                      crc_in;
   logic                      crc_fb;
   logic [cbtd_pkg::CRC_W-1:0] rcv_crc_q;
   cbtd_pkg::cbtd_err_t       err_d;
   logic                      any_err;
   logic [15:0]               wake_cnt_q;

   // Register writes only take effect in configuration mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prescaler_jump_config_q   <= cbtd_pkg::PRESCALER_JUMP_CONFIG_RST;
         segment_sampling_config_q <= cbtd_pkg::SEGMENT_SAMPLING_CONFIG_RST;
         phase2_wakeup_config_q    <= cbtd_pkg::PHASE2_WAKEUP_CONFIG_RST;
      end else if (reg_wr && cfg_mode) begin
         case (reg_addr)
            cbtd_pkg::PRESCALER_JUMP_CONFIG_OFS:   prescaler_jump_config_q   <= reg_wdata;
            cbtd_pkg::SEGMENT_SAMPLING_CONFIG_OFS: segment_sampling_config_q <= reg_wdata;
            cbtd_pkg::PHASE2_WAKEUP_CONFIG_OFS:
               phase2_wakeup_config_q <= reg_wdata & cbtd_pkg::PHASE2_WAKEUP_RD_MASK;
            default: ;
         endcase
      end
   end

   // Registered read; unmapped addresses and unused bits read zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            cbtd_pkg::PRESCALER_JUMP_CONFIG_OFS:   reg_rdata_q <= prescaler_jump_config_q;
            cbtd_pkg::SEGMENT_SAMPLING_CONFIG_OFS: reg_rdata_q <= segment_sampling_config_q;
            cbtd_pkg::PHASE2_WAKEUP_CONFIG_OFS:    reg_rdata_q <= phase2_wakeup_config_q;
            default:                               reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // Unpack configuration fields
   assign tcfg.quantum_prescaler =
      prescaler_jump_config_q[cbtd_pkg::QUANTUM_PRESCALER_LSB +: 6];
   assign tcfg.resync_jump_width =
      prescaler_jump_config_q[cbtd_pkg::RESYNC_JUMP_WIDTH_LSB +: 2];
   assign tcfg.propagation_length =
      segment_sampling_config_q[cbtd_pkg::PROPAGATION_LENGTH_LSB +: 3];
   assign tcfg.phase1_length =
      segment_sampling_config_q[cbtd_pkg::PHASE1_LENGTH_LSB +: 3];
   assign tcfg.triple_sample_select =
      segment_sampling_config_q[cbtd_pkg::TRIPLE_SAMPLE_SELECT_BIT];
   assign tcfg.phase2_length_select =
      segment_sampling_config_q[cbtd_pkg::PHASE2_LENGTH_SELECT_BIT];
   assign tcfg.phase2_length =
      phase2_wakeup_config_q[cbtd_pkg::PHASE2_LENGTH_LSB +: 3];

   // Quantum generation, segment timing and sampling
   cbtd_bit_timing u_timing (
      .clk         (clk),
      .rst_n       (rst_n),
      .cfg         (tcfg),
      .can_rx      (can_rx),
      .bus_idle    (field == cbtd_pkg::CBTD_IDLE),
      .tx_dominant (transmitting && !can_tx_q),
      .rx_sync     (rx_sync),
      .sample_q    (sample_s),
      .bit_val_q   (bit_val)
   );

   // Driven level; the acknowledge slot is always left recessive by us
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         can_tx_q <= 1'b1;
      end else if (!transmitting || field == cbtd_pkg::CBTD_ACK_SLOT) begin
         can_tx_q <= 1'b1;
      end else begin
         can_tx_q <= tx_bit;
      end
   end

   // Check sequence covers start of frame through data, stuff bits excluded
   assign crc_region = (field == cbtd_pkg::CBTD_SOF) || (field == cbtd_pkg::CBTD_ARB)
                    || (field == cbtd_pkg::CBTD_CTRL) || (field == cbtd_pkg::CBTD_DATA);
   assign crc_in     = transmitting ? tx_bit : bit_val;
   assign crc_fb     = crc_in ^ crc_seq_q[cbtd_pkg::CRC_W-1];

   // Running check sequence, shared by both directions
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         crc_seq_q <= '0;
      end else if (field == cbtd_pkg::CBTD_IDLE || field == cbtd_pkg::CBTD_IFS) begin
         crc_seq_q <= '0;
      end else if (sample_s && crc_bit_en && crc_region) begin
         crc_seq_q <= {crc_seq_q[cbtd_pkg::CRC_W-2:0], 1'b0}
                      ^ (crc_fb ? cbtd_pkg::CRC_POLY : '0);
      end
   end

   // Received sequence collected during the check field
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rcv_crc_q <= '0;
      end else if (sample_s && crc_bit_en && field == cbtd_pkg::CBTD_CRC) begin
         rcv_crc_q <= {rcv_crc_q[cbtd_pkg::CRC_W-2:0], bit_val};
      end
   end

   // Error checks at each sample point
   always_comb begin
      err_d = '0;
      if (sample_s) begin
         err_d.crc_err  = !transmitting && (field == cbtd_pkg::CBTD_CRC_DELIM)
                          && (rcv_crc_q != crc_seq_q);
         err_d.ack_err  = transmitting && (field == cbtd_pkg::CBTD_ACK_SLOT)
                          && bit_val;
         err_d.form_err = !bit_val && ((field == cbtd_pkg::CBTD_CRC_DELIM)
                          || (field == cbtd_pkg::CBTD_ACK_DELIM)
                          || (field == cbtd_pkg::CBTD_EOF)
                          || (field == cbtd_pkg::CBTD_IFS));
         err_d.bit_err  = transmitting && (bit_val != can_tx_q)
                          && !(can_tx_q && !bit_val
                               && ((field == cbtd_pkg::CBTD_ARB)
                                   || (field == cbtd_pkg::CBTD_ACK_SLOT)));
      end
   end
   assign any_err = |err_d;

   // Error pulses, error frame request and repeat request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_q         <= '0;
         error_frame_q <= 1'b0;
         repeat_req_q  <= 1'b0;
         sample_q      <= 1'b0;
         rx_bit_q      <= 1'b1;
      end else begin
         err_q         <= err_d;
         error_frame_q <= any_err;
         repeat_req_q  <= any_err && transmitting;
         sample_q      <= sample_s;
         rx_bit_q      <= bit_val;
      end
   end

   // Wake-up filter: dominant must persist to count; short glitches are dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_cnt_q <= 16'h0000;
         wake_q     <= 1'b0;
      end else if (!phase2_wakeup_config_q[cbtd_pkg::WAKEUP_FILTER_ENABLE_BIT]) begin
         wake_cnt_q <= 16'h0000;
         wake_q     <= !rx_sync;
      end else if (rx_sync) begin
         wake_cnt_q <= 16'h0000;
         wake_q     <= 1'b0;
      end else if (wake_cnt_q < 16'(WAKE_FILTER_CYCLES)) begin
         wake_cnt_q <= wake_cnt_q + 16'h0001;
         wake_q     <= 1'b0;
      end else begin
         wake_q     <= 1'b1;
      end
   end

endmodule // cbtd_top

//--- pkg/cbtd_pkg.sv
// Contract
// - The time quantum lasts two times the six-bit prescaler field plus one oscillator cycles.
// - A transmitter computes the check sequence over start of frame through data and sends it.
// - A receiver computes the same check sequence, compares it and flags a CRC error on mismatch.
// - A transmitter drives the acknowledge slot recessive and samples it for a dominant level.
// - A recessive acknowledge slot seen by the transmitter is an acknowledge error.
// - A dominant level in either delimiter, end of frame or interframe space is a form error.
// - A transmitter raises a bit error when the monitored level differs from the driven bit, except as below.
// - Recessive sent and dominant read in arbitration or the acknowledge slot is no bit error.
// - The two-bit jump width field plus one gives a jump width of one to four quanta.
// - With triple sampling set, the receive line is sampled three times and the majority taken.
// - Phase segment 2 is the larger of phase 1 and two quanta, or the phase 2 field when selected.
// - Timing registers change only in configuration mode; other writes are ignored.
package cbtd_pkg;

   // Register offsets
   localparam logic [7:0] PHASE2_WAKEUP_CONFIG_OFS    = 8'h28;
   localparam logic [7:0] SEGMENT_SAMPLING_CONFIG_OFS = 8'h29;
   localparam logic [7:0] PRESCALER_JUMP_CONFIG_OFS   = 8'h2A;

   // Reset values
   localparam logic [7:0] PHASE2_WAKEUP_CONFIG_RST    = 8'h00;
   localparam logic [7:0] SEGMENT_SAMPLING_CONFIG_RST = 8'h00;
   localparam logic [7:0] PRESCALER_JUMP_CONFIG_RST   = 8'h00;

   // Field positions
   localparam int QUANTUM_PRESCALER_LSB    = 0;
   localparam int RESYNC_JUMP_WIDTH_LSB    = 6;
   localparam int PROPAGATION_LENGTH_LSB   = 0;
   localparam int PHASE1_LENGTH_LSB        = 3;
   localparam int TRIPLE_SAMPLE_SELECT_BIT = 6;
   localparam int PHASE2_LENGTH_SELECT_BIT = 7;
   localparam int PHASE2_LENGTH_LSB        = 0;
   localparam int WAKEUP_FILTER_ENABLE_BIT = 6;
   localparam logic [7:0] PHASE2_WAKEUP_RD_MASK = 8'h47;

   // Timing constants in quanta
   localparam logic [3:0] PROCESSING_TIME = 4'h2;

   // Check sequence
   localparam int          CRC_W    = 15;
   localparam logic [14:0] CRC_POLY = 15'h4599;

   // Frame position reported by the frame engine
   typedef enum logic [3:0] {
      CBTD_IDLE      = 4'h0,
      CBTD_SOF       = 4'h1,
      CBTD_ARB       = 4'h3,
      CBTD_CTRL      = 4'h2,
      CBTD_DATA      = 4'h6,
      CBTD_CRC       = 4'h7,
      CBTD_CRC_DELIM = 4'h5,
      CBTD_ACK_SLOT  = 4'h4,
      CBTD_ACK_DELIM = 4'hC,
      CBTD_EOF       = 4'hD,
      CBTD_IFS       = 4'hF,
      CBTD_ERRFRM    = 4'hE
   } cbtd_field_t;

   // Bit timing segment
   typedef enum logic [1:0] {
      CBTD_SEG_SYNC  = 2'h0,
      CBTD_SEG_TSEG1 = 2'h1,
      CBTD_SEG_TSEG2 = 2'h3
   } cbtd_seg_t;

   // Bit timing configuration
   typedef struct packed {
      logic [5:0] quantum_prescaler;
      logic [1:0] resync_jump_width;
      logic [2:0] propagation_length;
      logic [2:0] phase1_length;
      logic [2:0] phase2_length;
      logic       triple_sample_select;
      logic       phase2_length_select;
   } cbtd_timing_t;

   // Error events, one-cycle pulses
   typedef struct packed {
      logic crc_err;
      logic ack_err;
      logic form_err;
      logic bit_err;
   } cbtd_err_t;

endpackage

//--- core/cbtd_bit_timing.sv
`timescale 1ns/1ps
module cbtd_bit_timing (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Configuration
   input  wire cbtd_pkg::cbtd_timing_t cfg,
   // Bus side
   input  wire logic                  can_rx,
   input  wire logic                  bus_idle,
   input  wire logic                  tx_dominant,
   // Results
   output logic                       rx_sync,
   output logic                       sample_q,
   output logic                       bit_val_q
);

   logic                rx_m_q;
   logic                rx_s_q;
   logic                rx_p_q;
   logic [5:0]          pres_q;
   logic                half_q;
   cbtd_pkg::cbtd_seg_t seg_q;
   logic [4:0]          cnt_q;
   logic [4:0]          ext_q;
   logic [4:0]          shrink_q;
   logic                synced_q;
   logic [1:0]          hist_q;
   logic                half_tick;
   logic                tq_tick;
   logic [3:0]          ph1_len;
   logic [3:0]          ph2_len;
   logic [4:0]          t1_end;
   logic [4:0]          t2_end;
   logic [4:0]          sjw_len;
   logic                sync_ok;
   logic                restart;
   logic                sp;
   logic                bit_end;
   logic                maj;

   // Pin synchroniser; the second stage feeds logic, the third only the falling-edge detect
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
         rx_p_q <= 1'b1;
      end else begin
         rx_m_q <= can_rx;
         rx_s_q <= rx_m_q;
         rx_p_q <= rx_s_q;
      end
   end
   assign rx_sync = rx_s_q;

   // Segment lengths in quanta
   assign ph1_len = {1'b0, cfg.phase1_length} + 4'h1;
   assign ph2_len = cfg.phase2_length_select ? {1'b0, cfg.phase2_length} + 4'h1
                  : ((ph1_len > cbtd_pkg::PROCESSING_TIME) ? ph1_len
                                                          : cbtd_pkg::PROCESSING_TIME);
   assign t1_end  = {2'h0, cfg.propagation_length} + 5'h1 + {1'b0, ph1_len} + ext_q;
   assign t2_end  = {1'b0, ph2_len} - shrink_q;
   assign sjw_len = {3'h0, cfg.resync_jump_width} + 5'h1;

   // Half-quantum tick every prescaler+1 clocks, so a quantum is 2*(p+1) clocks
   assign half_tick = (pres_q == cfg.quantum_prescaler);
   assign tq_tick   = half_tick && half_q;
   assign sp        = tq_tick && (seg_q == cbtd_pkg::CBTD_SEG_TSEG1) && (cnt_q == t1_end - 5'h1);
   assign bit_end   = tq_tick && (seg_q == cbtd_pkg::CBTD_SEG_TSEG2) && (cnt_q >= t2_end - 5'h1);

   // Falling edge usable only once per bit and after a recessive sample
   assign sync_ok = rx_p_q && !rx_s_q && bit_val_q && !synced_q;
   assign restart = sync_ok && (bus_idle || ((seg_q == cbtd_pkg::CBTD_SEG_TSEG2)
                    && ((t2_end - cnt_q) <= sjw_len)));

   // Prescaler, restarted with the bit on a hard sync
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pres_q <= 6'h00;
         half_q <= 1'b0;
      end else if (restart) begin
         pres_q <= 6'h00;
         half_q <= 1'b0;
      end else begin
         pres_q <= half_tick ? 6'h00 : pres_q + 6'h01;
         half_q <= half_tick ? !half_q : half_q;
      end
   end

   // Segment sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seg_q <= cbtd_pkg::CBTD_SEG_SYNC;
         cnt_q <= 5'h00;
      end else if (restart) begin
         seg_q <= cbtd_pkg::CBTD_SEG_SYNC;
         cnt_q <= 5'h00;
      end else if (tq_tick) begin
         case (seg_q)
            cbtd_pkg::CBTD_SEG_SYNC: begin
               seg_q <= cbtd_pkg::CBTD_SEG_TSEG1;
               cnt_q <= 5'h00;
            end
            cbtd_pkg::CBTD_SEG_TSEG1: begin
               if (sp) begin
                  seg_q <= cbtd_pkg::CBTD_SEG_TSEG2;
                  cnt_q <= 5'h00;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            cbtd_pkg::CBTD_SEG_TSEG2: begin
               if (bit_end) begin
                  seg_q <= cbtd_pkg::CBTD_SEG_SYNC;
                  cnt_q <= 5'h00;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            default: begin
               seg_q <= cbtd_pkg::CBTD_SEG_SYNC;
               cnt_q <= 5'h00;
            end
         endcase
      end
   end

   // Resynchronisation: stretch phase 1 or cut phase 2 by at most the jump width
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_q    <= 5'h00;
         shrink_q <= 5'h00;
         synced_q <= 1'b0;
      end else if (bit_end) begin
         ext_q    <= 5'h00;
         shrink_q <= 5'h00;
         synced_q <= 1'b0;
      end else if (restart) begin
         ext_q    <= 5'h00;
         shrink_q <= 5'h00;
         synced_q <= 1'b1;
      end else if (sync_ok && (seg_q == cbtd_pkg::CBTD_SEG_TSEG1) && !tx_dominant) begin
         ext_q    <= ((cnt_q + 5'h01) < sjw_len) ? cnt_q + 5'h01 : sjw_len;
         synced_q <= 1'b1;
      end else if (sync_ok && (seg_q == cbtd_pkg::CBTD_SEG_TSEG2)) begin
         shrink_q <= sjw_len;
         synced_q <= 1'b1;
      end
   end

   // History of half-quantum samples ahead of the sample point
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hist_q <= 2'h3;
      end else if (half_tick) begin
         hist_q <= {hist_q[0], rx_s_q};
      end
   end

   // Two earlier half-quantum samples plus the current level vote
   assign maj = (hist_q[1] & hist_q[0]) | (hist_q[1] & rx_s_q) | (hist_q[0] & rx_s_q);

   // Sampled bit; idle bus is recessive
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sample_q  <= 1'b0;
         bit_val_q <= 1'b1;
      end else begin
         sample_q <= sp;
         if (sp) begin
            bit_val_q <= cfg.triple_sample_select ? maj : rx_s_q;
         end
      end
   end

endmodule // cbtd_bit_timing

//--- dv/cbtd_top_asserts.sv
`timescale 1ns/1ps
module cbtd_checker #(
   parameter int WAKE_FILTER_CYCLES = 16
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Frame engine and bus drive
   input wire cbtd_pkg::cbtd_field_t field,
   input wire logic                  transmitting,
   input wire logic                  tx_bit,
   input wire logic                  can_tx_q,
   // Results
   input wire logic                  sample_q,
   input wire logic                  rx_bit_q,
   input wire cbtd_pkg::cbtd_err_t   err_q,
   input wire logic                  error_frame_q,
   input wire logic                  repeat_req_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Drive stays recessive wherever this node does not own the bit
   ack_release_a: assert property (
      (!transmitting || field == cbtd_pkg::CBTD_ACK_SLOT) |=> can_tx_q)
      else $error("drive not recessive in acknowledge slot or when idle");
   tx_follow_a: assert property (
      transmitting && field != cbtd_pkg::CBTD_ACK_SLOT |=> can_tx_q == $past(tx_bit))
      else $error("drive does not follow the requested bit");
   // Error events are single pulses aligned with the sample pulse
   err_sample_a: assert property (
      (|err_q) |-> sample_q ##1 (!sample_q && err_q == 4'h0))
      else $error("error pulse not aligned with one sample pulse");
   err_frame_a: assert property (
      error_frame_q == (|err_q))
      else $error("error frame request does not match error events");
   repeat_tx_a: assert property (
      (error_frame_q || repeat_req_q) |-> error_frame_q && repeat_req_q == $past(transmitting))
      else $error("repeat request wrong for role");
   ack_err_a: assert property (
      err_q.ack_err |-> rx_bit_q && $past(transmitting) && $past(field) == cbtd_pkg::CBTD_ACK_SLOT)
      else $error("acknowledge error outside a recessive slot");
   crc_err_a: assert property (
      err_q.crc_err |-> !$past(transmitting) && $past(field) == cbtd_pkg::CBTD_CRC_DELIM)
      else $error("check sequence error outside receiver delimiter");
   form_err_a: assert property (
      err_q.form_err |-> !rx_bit_q && $past(field) inside {cbtd_pkg::CBTD_CRC_DELIM,
         cbtd_pkg::CBTD_ACK_DELIM, cbtd_pkg::CBTD_EOF, cbtd_pkg::CBTD_IFS})
      else $error("form error outside fixed form fields");
   bit_err_a: assert property (
      err_q.bit_err |-> $past(transmitting) && $past(field) != cbtd_pkg::CBTD_ACK_SLOT)
      else $error("bit error while receiving or in acknowledge slot");
endmodule // cbtd_checker

bind cbtd_top cbtd_checker #(.WAKE_FILTER_CYCLES(WAKE_FILTER_CYCLES)) chk_u (
   .clk(clk), .rst_n(rst_n), .field(field), .transmitting(transmitting),
   .tx_bit(tx_bit), .can_tx_q(can_tx_q), .sample_q(sample_q), .rx_bit_q(rx_bit_q),
   .err_q(err_q), .error_frame_q(error_frame_q), .repeat_req_q(repeat_req_q));

//--- dv/cbtd_bus_node.sv
`timescale 1ns/1ps
module cbtd_bus_node (
   // Clock
   input  wire logic clk,
   // Bus
   input  wire logic dut_tx,
   input  wire logic node_bit,
   output logic      can_rx
);
   logic node_q = 1'b1;
   // Other node launches its bit a cycle late, like a remote transceiver
   always_ff @(posedge clk) begin
      node_q <= node_bit;
   end
   // Wired-AND: a dominant from either node wins, acknowledge included
   assign can_rx = dut_tx & node_q;
endmodule // cbtd_bus_node

//--- dv/cbtd_tb_top.sv
`timescale 1ns/1ps
module cbtd_tb_top;
   typedef struct {logic [7:0] c1, c2, c3, rb3; int per;} cbtd_row_t;
   // Bench signals
   logic                  clk, rst_n, cfg_mode, reg_wr, reg_rd, can_rx, can_tx_q, sample_q;
   logic                  rx_bit_q, transmitting, tx_bit, node_bit, error_frame_q;
   logic                  repeat_req_q, wake_q;
   logic [7:0]            reg_addr, reg_wdata, reg_rdata_q, rv;
   logic [14:0]           crc_seq_q;
   cbtd_pkg::cbtd_field_t field;
   cbtd_pkg::cbtd_err_t   err_q;
   int                    num_errors = 0, check_count = 0, span;
   // Config bytes, expected readback of the masked register, clocks per bit
   cbtd_row_t rows [4] = '{'{8'h01, 8'h91, 8'h03, 8'h03, 40}, '{8'hC2, 8'h1A, 8'hFF, 8'h47, 72},
                           '{8'h40, 8'hC0, 8'h01, 8'h01, 10}, '{8'h00, 8'h00, 8'h00, 8'h00, 10}};
   cbtd_pkg::cbtd_field_t form_f [4] = '{cbtd_pkg::CBTD_CRC_DELIM, cbtd_pkg::CBTD_ACK_DELIM,
                                         cbtd_pkg::CBTD_EOF, cbtd_pkg::CBTD_IFS};
   localparam logic [25:0] FRAME_BITS = 26'h0B59A6D;

   // Stuff-bit input tied: stuffing is outside this block
   cbtd_top #(.WAKE_FILTER_CYCLES(2)) dut_u (
      .clk(clk), .rst_n(rst_n), .cfg_mode(cfg_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .can_rx(can_rx),
      .can_tx_q(can_tx_q), .field(field), .transmitting(transmitting), .tx_bit(tx_bit),
      .crc_bit_en(1'b1), .sample_q(sample_q), .rx_bit_q(rx_bit_q), .crc_seq_q(crc_seq_q),
      .err_q(err_q), .error_frame_q(error_frame_q), .repeat_req_q(repeat_req_q),
      .wake_q(wake_q));
   cbtd_bus_node node_u (.clk(clk), .dut_tx(can_tx_q), .node_bit(node_bit), .can_rx(can_rx));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Waits for the next sample pulse; span keeps the clocks it took
   task automatic wait_s();
      span = 0;
      do begin
         @(negedge clk);
         span++;
      end while (sample_q !== 1'b1 && span < 200);
      if (span >= 200) chk("sample pulse", 1, 0);
   endtask

   task automatic wr(input logic [7:0] a, d, input logic m);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata, cfg_mode} <= {1'b1, a, d, m};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rv = reg_rdata_q;
   endtask

   // One bit: inputs change just after a sample, flags checked at the next one
   task automatic bt(input cbtd_pkg::cbtd_field_t f, input logic t, b, n, input logic [5:0] e);
      @(posedge clk);
      {field, transmitting, tx_bit, node_bit} <= {f, t, b, n};
      wait_s();
      chk("error flags", e, {err_q, error_frame_q, repeat_req_q});
      chk("received bit", b & n, rx_bit_q);
   endtask

   function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
      return {c[13:0], 1'b0} ^ ((b ^ c[14]) ? cbtd_pkg::CRC_POLY : 15'h0000);
   endfunction

   // Whole frame; the other node stays recessive for a transmitter except to acknowledge, or sends to a receiver
   task automatic frame(input logic t, ack, flip);
      logic [14:0]           c;
      logic                  b;
      cbtd_pkg::cbtd_field_t f;
      c = 15'h0000;
      repeat (2) bt(cbtd_pkg::CBTD_IDLE, 1'b0, 1'b1, 1'b1, 6'h00);
      for (int i = 25; i >= 0; i--) begin
         b = FRAME_BITS[i];
         f = (i == 25) ? cbtd_pkg::CBTD_SOF : (i > 13) ? cbtd_pkg::CBTD_ARB
           : (i > 7) ? cbtd_pkg::CBTD_CTRL : cbtd_pkg::CBTD_DATA;
         bt(f, t, b, t | b, 6'h00);
         c = crc_step(c, b);
      end
      repeat (3) @(negedge clk);
      chk("check sequence", c, crc_seq_q);
      for (int i = 14; i >= 0; i--) begin
         b = c[i] ^ (flip && i == 0);
         bt(cbtd_pkg::CBTD_CRC, t, b, t | b, 6'h00);
      end
      bt(cbtd_pkg::CBTD_CRC_DELIM, t, 1'b1, 1'b1, (!t && flip) ? 6'h22 : 6'h00);
      bt(cbtd_pkg::CBTD_ACK_SLOT, t, 1'b1, !ack, (t && !ack) ? 6'h13 : 6'h00);
      bt(cbtd_pkg::CBTD_ACK_DELIM, t, 1'b1, 1'b1, 6'h00);
      repeat (7) bt(cbtd_pkg::CBTD_EOF, t, 1'b1, 1'b1, 6'h00);
   endtask

   // Main sequence
   initial begin
      {rst_n, cfg_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = 20'h00000;
      field = cbtd_pkg::CBTD_IDLE;
      {transmitting, tx_bit, node_bit} = 3'b011;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("reset outputs", 32'h280, {reg_rdata_q, can_tx_q, sample_q, rx_bit_q, err_q,
          error_frame_q, repeat_req_q, wake_q});
      chk("reset check sequence", 0, crc_seq_q);
      @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[r]) begin
         wr(8'h2A, rows[r].c1, 1'b1);
         wr(8'h29, rows[r].c2, 1'b1);
         wr(8'h28, rows[r].c3, 1'b1);
         rd(8'h2A);
         chk("prescaler_jump_config", rows[r].c1, rv);
         rd(8'h29);
         chk("segment_sampling_config", rows[r].c2, rv);
         rd(8'h28);
         chk("phase2_wakeup_config", rows[r].rb3, rv);
         repeat (3) wait_s();
         chk("bit period", rows[r].per, span);
      end
      wr(8'h2B, 8'hFF, 1'b1);
      rd(8'h2B);
      chk("unmapped read", 0, rv);
      wr(8'h2A, 8'h15, 1'b0);
      rd(8'h2A);
      chk("write outside config mode", 0, rv);
      frame(1'b1, 1'b1, 1'b0);
      frame(1'b1, 1'b0, 1'b0);
      frame(1'b0, 1'b1, 1'b0);
      frame(1'b0, 1'b1, 1'b1);
      for (int k = 0; k < 4; k++) begin
         frame(1'b0, 1'b1, 1'b0);
         bt(form_f[k], 1'b0, 1'b1, 1'b0, 6'h0A);
      end
      bt(cbtd_pkg::CBTD_IDLE, 1'b0, 1'b1, 1'b1, 6'h00);
      bt(cbtd_pkg::CBTD_ARB, 1'b1, 1'b1, 1'b0, 6'h00);
      bt(cbtd_pkg::CBTD_ACK_SLOT, 1'b1, 1'b1, 1'b0, 6'h00);
      bt(cbtd_pkg::CBTD_DATA, 1'b1, 1'b1, 1'b0, 6'h07);
      // Filter off: dominant bus shows at once; on: a one-clock glitch is dropped
      chk("wake bypass", 1, wake_q);
      wr(8'h28, 8'h40, 1'b1);
      @(posedge clk);
      {transmitting, node_bit} <= 2'b01;
      repeat (6) @(posedge clk);
      node_bit <= 1'b0;
      @(posedge clk);
      node_bit <= 1'b1;
      repeat (8) begin
         @(negedge clk);
         chk("wake glitch", 0, wake_q);
      end
      @(posedge clk);
      node_bit <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("wake filtered", 1, wake_q);
      complete_run();
   end

   // Watchdog, well beyond the expected run length
   initial begin
      #1000000;
      num_errors++;
      complete_run();
   end
endmodule // cbtd_tb_top
